// >>> include/gpio_port_regs.vh
// Constants for the general-purpose port block with alternate functions.
`ifndef GPIO_PORT_REGS_VH
`define GPIO_PORT_REGS_VH
// ==========================================================================
// Port widths and reset values
`define PORT_A_WIDTH        8
`define PORT_B_WIDTH        8
`define PORT_C_WIDTH        5
`define PORT_RESET_VALUE    8'h00
// ==========================================================================
// Alternate-function line positions
`define TIMER_PIN_BIT       1
`define SIN_PIN_BIT         2
`define SERIAL_DATA_OUT_PIN_PIN_BIT        3
`define SCK_PIN_BIT         4
`define ARIN_PIN_BIT        6
`define AROUT_PIN_BIT       7
// ==========================================================================
// Miscellaneous register: serial output enable field position
`define MISC_SERIAL_DATA_OUT_PIN_EN_BIT    0
// ==========================================================================
// Interrupt trigger encodings, one code per port
`define TRIG_FALLING        2'h0
`define TRIG_RISING         2'h1
`define TRIG_LOW_LEVEL      2'h2
`endif

// >>> core/gpio_port_alt_function_mux.v
// Three ports (8, 8 and 5 bits wide) with mode decode, overrides and interrupt triggers.
`include "gpio_port_regs.vh"

module gpio_port_alt_function_mux #(
  parameter AW = `PORT_A_WIDTH,
  parameter BW = `PORT_B_WIDTH,
  parameter CW = `PORT_C_WIDTH
) (
  // Clock and reset
  input  wire          clk,
  input  wire          rstn,
  // Register write port: one strobe per register, byte of write data
  input  wire [7:0]    wdata,
  input  wire [2:0]    wr_data,
  input  wire [2:0]    wr_dir,
  input  wire [2:0]    wr_opt,
  input  wire          wr_misc,
  input  wire          wr_trig,
  // Register read-back of the data registers (pin level for inputs)
  output reg  [AW-1:0] first_port_level_reg,
  output reg  [BW-1:0] second_port_level_reg,
  output reg  [CW-1:0] third_port_level_reg,
  // Read-back of direction registers
  output reg  [BW-1:0] second_port_direction,
  output reg  [CW-1:0] third_port_direction,
  // Pins of port A
  input  wire [AW-1:0] pa_in,
  output reg  [AW-1:0] pa_out,
  output reg  [AW-1:0] pa_oe,
  output reg  [AW-1:0] pa_pullup,
  output reg  [AW-1:0] pa_analog,
  // Pins of port B
  input  wire [BW-1:0] pb_in,
  output reg  [BW-1:0] pb_out,
  output reg  [BW-1:0] pb_oe,
  output reg  [BW-1:0] pb_pullup,
  // Pins of port C
  input  wire [CW-1:0] pc_in,
  output reg  [CW-1:0] pc_out,
  output reg  [CW-1:0] pc_oe,
  output reg  [CW-1:0] pc_pullup,
  output reg  [CW-1:0] pc_analog,
  // Peripheral controls
  input  wire          timer_pin_drive_select,
  input  wire          timer_out,
  input  wire          pwm_pin_drive_enable,
  input  wire          pwm_out,
  input  wire          serial_clock_source_select,
  input  wire          spi_serial_data_out_pin,
  input  wire          spi_sck_out,
  // Peripheral inputs fed from pins
  output reg           timer_in,
  output reg           reload_timer_in,
  output reg           spi_sin,
  output reg           spi_sck_in,
  // Interrupt requests, one per port
  output reg  [2:0]    port_irq
);

  // ========================================================================
  // Port registers
  reg [AW-1:0] dra_q, ddra_q, ora_q;
  reg [BW-1:0] drb_q, second_port_direction_q, orb_q;
  reg [CW-1:0] drc_q, third_port_direction_q, orc_q;
  reg          misc_q;
  reg [5:0]    trig_q;

  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      dra_q  <= {AW{1'b0}};
      ddra_q <= {AW{1'b0}};
      ora_q  <= {AW{1'b0}};
      drb_q  <= {BW{1'b0}};
      second_port_direction_q <= {BW{1'b0}};
      orb_q  <= {BW{1'b0}};
      drc_q  <= {CW{1'b0}};
      third_port_direction_q <= {CW{1'b0}};
      orc_q  <= {CW{1'b0}};
      misc_q <= 1'b0;
      trig_q <= 6'h00;
    end else begin
      // Writes land on the next edge.
      if (wr_data[0]) dra_q  <= wdata[AW-1:0];
      if (wr_dir[0])  ddra_q <= wdata[AW-1:0];
      if (wr_opt[0])  ora_q  <= wdata[AW-1:0];
      if (wr_data[1]) drb_q  <= wdata[BW-1:0];
      if (wr_dir[1])  second_port_direction_q <= wdata[BW-1:0];
      if (wr_opt[1])  orb_q  <= wdata[BW-1:0];
      if (wr_data[2]) drc_q  <= wdata[CW-1:0];
      if (wr_dir[2])  third_port_direction_q <= wdata[CW-1:0];
      if (wr_opt[2])  orc_q  <= wdata[CW-1:0];
      if (wr_misc)    misc_q <= wdata[`MISC_SERIAL_DATA_OUT_PIN_EN_BIT];
      if (wr_trig)    trig_q <= wdata[5:0];
    end
  end

  // ========================================================================
  // Pin synchronisers
  reg [AW-1:0] pa_s1_q, pa_s2_q;
  reg [BW-1:0] pb_s1_q, pb_s2_q;
  reg [CW-1:0] pc_s1_q, pc_s2_q;

  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pa_s1_q <= {AW{1'b0}};
      pa_s2_q <= {AW{1'b0}};
      pb_s1_q <= {BW{1'b0}};
      pb_s2_q <= {BW{1'b0}};
      pc_s1_q <= {CW{1'b0}};
      pc_s2_q <= {CW{1'b0}};
    end else begin
      pa_s1_q <= pa_in;
      pa_s2_q <= pa_s1_q;
      pb_s1_q <= pb_in;
      pb_s2_q <= pb_s1_q;
      pc_s1_q <= pc_in;
      pc_s2_q <= pc_s1_q;
    end
  end

  // ========================================================================
  // Mode decode. Output data low pulls down; open drain never drives high,
  // so a high bit releases the pin rather than driving it.
  reg [AW-1:0] pa_out_d, pa_oe_d, pa_pu_d, pa_an_d, pa_int_d;
  reg [BW-1:0] pb_out_d, pb_oe_d, pb_pu_d, pb_int_d;
  reg [CW-1:0] pc_out_d, pc_oe_d, pc_pu_d, pc_an_d, pc_int_d;
  integer i;
  integer j;

  always @* begin
    for (i = 0; i < AW; i = i + 1) begin
      pa_pu_d[i]  = ~ddra_q[i] & ~dra_q[i];
      pa_int_d[i] = ~ddra_q[i] & ora_q[i] & ~dra_q[i];
      pa_an_d[i]  = ~ddra_q[i] & ora_q[i] & dra_q[i];
      pa_out_d[i] = dra_q[i];
      // Push-pull drives both levels, open drain only sinks.
      pa_oe_d[i]  = ddra_q[i] & (ora_q[i] | ~dra_q[i]);
    end
    for (i = 0; i < BW; i = i + 1) begin
      pb_pu_d[i]  = ~second_port_direction_q[i] & ~drb_q[i];
      pb_int_d[i] = ~second_port_direction_q[i] & orb_q[i] & ~drb_q[i];
      pb_out_d[i] = drb_q[i];
      pb_oe_d[i]  = second_port_direction_q[i] & (orb_q[i] | ~drb_q[i]);
    end
    for (i = 0; i < CW; i = i + 1) begin
      pc_pu_d[i]  = ~third_port_direction_q[i] & ~drc_q[i];
      pc_int_d[i] = ~third_port_direction_q[i] & orc_q[i] & ~drc_q[i];
      pc_an_d[i]  = ~third_port_direction_q[i] & orc_q[i] & drc_q[i];
      pc_out_d[i] = drc_q[i];
      pc_oe_d[i]  = third_port_direction_q[i] & (orc_q[i] | ~drc_q[i]);
    end
    // Port B has no analog path: option 1, data 1 is a plain input there.
    // Alternate-function overrides take the pin away from the port.
    if (timer_pin_drive_select) begin
      pc_out_d[`TIMER_PIN_BIT] = timer_out;
      pc_oe_d[`TIMER_PIN_BIT]  = 1'b1;
      pc_pu_d[`TIMER_PIN_BIT]  = 1'b0;
      pc_an_d[`TIMER_PIN_BIT]  = 1'b0;
      pc_int_d[`TIMER_PIN_BIT] = 1'b0;
    end
    if (pwm_pin_drive_enable) begin
      pb_out_d[`AROUT_PIN_BIT] = pwm_out;
      pb_oe_d[`AROUT_PIN_BIT]  = 1'b1;
      pb_pu_d[`AROUT_PIN_BIT]  = 1'b0;
      pb_int_d[`AROUT_PIN_BIT] = 1'b0;
    end
    if (misc_q) begin
      pc_out_d[`SERIAL_DATA_OUT_PIN_PIN_BIT] = spi_serial_data_out_pin;
      pc_oe_d[`SERIAL_DATA_OUT_PIN_PIN_BIT]  = 1'b1;
      pc_pu_d[`SERIAL_DATA_OUT_PIN_PIN_BIT]  = 1'b0;
      pc_an_d[`SERIAL_DATA_OUT_PIN_PIN_BIT]  = 1'b0;
      pc_int_d[`SERIAL_DATA_OUT_PIN_PIN_BIT] = 1'b0;
    end
    // Master clock only in push-pull output with the select set; with the
    // select low the pin stays ordinary port I/O.
    if (serial_clock_source_select && third_port_direction_q[`SCK_PIN_BIT] &&
        orc_q[`SCK_PIN_BIT]) begin
      pc_out_d[`SCK_PIN_BIT] = spi_sck_out;
      pc_oe_d[`SCK_PIN_BIT]  = 1'b1;
    end
  end

  // ========================================================================
  // Read-back: inputs show the live pin, outputs the latch.
  wire [AW-1:0] pa_rd = (ddra_q & dra_q) | (~ddra_q & pa_s2_q);
  wire [BW-1:0] pb_rd = (second_port_direction_q & drb_q) | (~second_port_direction_q & pb_s2_q);
  wire [CW-1:0] pc_rd = (third_port_direction_q & drc_q) | (~third_port_direction_q & pc_s2_q);

  // ========================================================================
  // Interrupt trigger per port: any enabled pin meeting its condition.
  reg  [AW-1:0] pa_prev_q;
  reg  [BW-1:0] pb_prev_q;
  reg  [CW-1:0] pc_prev_q;
  wire [2:0]    fall_hit, rise_hit, low_hit;
  reg  [2:0]    irq_d;

  assign fall_hit = {|(pc_int_d & pc_prev_q & ~pc_s2_q),
                     |(pb_int_d & pb_prev_q & ~pb_s2_q),
                     |(pa_int_d & pa_prev_q & ~pa_s2_q)};
  assign rise_hit = {|(pc_int_d & ~pc_prev_q & pc_s2_q),
                     |(pb_int_d & ~pb_prev_q & pb_s2_q),
                     |(pa_int_d & ~pa_prev_q & pa_s2_q)};
  assign low_hit  = {|(pc_int_d & ~pc_s2_q),
                     |(pb_int_d & ~pb_s2_q),
                     |(pa_int_d & ~pa_s2_q)};

  always @* begin
    for (j = 0; j < 3; j = j + 1) begin
      case (trig_q[2*j +: 2])
        `TRIG_FALLING:   irq_d[j] = fall_hit[j];
        `TRIG_RISING:    irq_d[j] = rise_hit[j];
        `TRIG_LOW_LEVEL: irq_d[j] = low_hit[j];
        default:         irq_d[j] = 1'b0;
      endcase
    end
  end

  // ========================================================================
  // Output registers
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pa_prev_q             <= {AW{1'b1}};
      pb_prev_q             <= {BW{1'b1}};
      pc_prev_q             <= {CW{1'b1}};
      first_port_level_reg  <= {AW{1'b0}};
      second_port_level_reg <= {BW{1'b0}};
      third_port_level_reg  <= {CW{1'b0}};
      second_port_direction <= {BW{1'b0}};
      third_port_direction  <= {CW{1'b0}};
      pa_out    <= {AW{1'b0}};
      pa_oe     <= {AW{1'b0}};
      pa_pullup <= {AW{1'b1}};
      pa_analog <= {AW{1'b0}};
      pb_out    <= {BW{1'b0}};
      pb_oe     <= {BW{1'b0}};
      pb_pullup <= {BW{1'b1}};
      pc_out    <= {CW{1'b0}};
      pc_oe     <= {CW{1'b0}};
      pc_pullup <= {CW{1'b1}};
      pc_analog <= {CW{1'b0}};
      timer_in        <= 1'b0;
      reload_timer_in <= 1'b0;
      spi_sin         <= 1'b0;
      spi_sck_in      <= 1'b0;
      port_irq        <= 3'h0;
    end else begin
      pa_prev_q             <= pa_s2_q;
      pb_prev_q             <= pb_s2_q;
      pc_prev_q             <= pc_s2_q;
      first_port_level_reg  <= pa_rd;
      second_port_level_reg <= pb_rd;
      third_port_level_reg  <= pc_rd;
      second_port_direction <= second_port_direction_q;
      third_port_direction  <= third_port_direction_q;
      pa_out    <= pa_out_d;
      pa_oe     <= pa_oe_d;
      pa_pullup <= pa_pu_d;
      pa_analog <= pa_an_d;
      pb_out    <= pb_out_d;
      pb_oe     <= pb_oe_d;
      pb_pullup <= pb_pu_d;
      pc_out    <= pc_out_d;
      pc_oe     <= pc_oe_d;
      pc_pullup <= pc_pu_d;
      pc_analog <= pc_an_d;
      // Timer input follows the pin while the port owns it.
      timer_in        <= pc_s2_q[`TIMER_PIN_BIT] & ~timer_pin_drive_select;
      reload_timer_in <= pb_s2_q[`ARIN_PIN_BIT];
      spi_sin         <= pc_s2_q[`SIN_PIN_BIT] &
                         ~third_port_direction_q[`SIN_PIN_BIT];
      spi_sck_in      <= pc_s2_q[`SCK_PIN_BIT] &
                         ~third_port_direction_q[`SCK_PIN_BIT] &
                         ~serial_clock_source_select;
      port_irq        <= irq_d;
    end
  end

endmodule

// >>> verification/gpio_port_properties.sv
// Checker of pin modes, overrides and input timing of the port block.
module gpio_port_checker #(
  parameter AW = 8,
  parameter BW = 8,
  parameter CW = 5
) (
  input wire          clk,
  input wire          rstn,
  input wire [AW-1:0] pa_oe,
  input wire [AW-1:0] pa_pullup,
  input wire [AW-1:0] pa_analog,
  input wire [BW-1:0] pb_in,
  input wire [BW-1:0] pb_oe,
  input wire [BW-1:0] pb_out,
  input wire [BW-1:0] pb_pullup,
  input wire [BW-1:0] second_port_direction,
  input wire [BW-1:0] second_port_level_reg,
  input wire [CW-1:0] pc_oe,
  input wire [CW-1:0] pc_out,
  input wire          timer_pin_drive_select,
  input wire          timer_out,
  input wire          pwm_pin_drive_enable,
  input wire          pwm_out,
  input wire          reload_timer_in,
  input wire [2:0]    port_irq
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================================
  // Helper logic
  // Pin history is trusted only once it holds samples taken after reset.
  logic [1:0] up_q;
  always @(posedge clk or negedge rstn)
    if (!rstn) up_q <= 2'h0;
    else if (up_q != 2'h3) up_q <= up_q + 2'h1;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  // ==========================================================================
  // Assertions
  reset_clear_a: assert property (disable iff (1'b0)
    !rstn |-> pa_oe == '0 && &pa_pullup && port_irq == 3'h0)
    else $error("outputs not cleared in reset");
  timer_drive_a: assert property (
    up_q != 2'h0 && $past(timer_pin_drive_select) |->
    pc_oe[1] && pc_out[1] == $past(timer_out))
    else $error("timer pin not driven");
  pwm_drive_a: assert property (
    up_q != 2'h0 && $past(pwm_pin_drive_enable) |->
    pb_oe[7] && pb_out[7] == $past(pwm_out))
    else $error("pwm pin not driven");
  input_quiet_a: assert property (
    (pb_oe[5:0] & ~second_port_direction[5:0]
     & ~$past(second_port_direction[5:0])) == 6'h00)
    else $error("input pin driven");
  pull_output_a: assert property (
    (pb_pullup[5:0] & pb_oe[5:0]) == 6'h00 && (pa_pullup & pa_oe) == '0)
    else $error("pull-up on output");
  analog_excl_a: assert property (
    (pa_analog & (pa_pullup | pa_oe)) == '0)
    else $error("analog pin not isolated");
  reload_sync_a: assert property (
    up_q == 2'h3 |-> reload_timer_in == $past(pb_in[6], 3))
    else $error("reload input latency wrong");
  level_sync_a: assert property (
    (up_q == 2'h3 && !second_port_direction[0]) [*4] |->
    second_port_level_reg[0] == $past(pb_in[0], 3))
    else $error("pin read-back latency wrong");
  cover property (timer_pin_drive_select && pc_oe[1]);
  cover property (pwm_pin_drive_enable && pb_oe[7]);
  cover property (port_irq != 3'h0);
endmodule
bind gpio_port_alt_function_mux gpio_port_checker #(
  .AW(AW), .BW(BW), .CW(CW)) chk (.*);

// >>> verification/pin_world.sv
// External circuitry on one port: resolves each pin from all its drivers.
module pin_world #(
  parameter W = 8
) (
  input  wire         clk,
  input  wire [W-1:0] oe,
  input  wire [W-1:0] out,
  input  wire [W-1:0] pu,
  input  wire [W-1:0] ext_en,
  input  wire [W-1:0] ext_val,
  output logic [W-1:0] pin
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [W-1:0] float_q = '0;
  // A floating line must not pass for a stable level, so it wanders.
  always @(posedge clk) float_q <= ~float_q;
  always_comb pin = (oe & out) | (~oe & ext_en & ext_val)
    | (~oe & ~ext_en & (pu | float_q));
endmodule

// >>> verification/testbench.sv
// Self-checking bench for the port block with alternate functions.
`include "gpio_port_regs.vh"
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin \
  err_count++; $display("wrong value %s exp %h got %h", n, e, g); end end
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic       clk = 0, rstn = 1, wr_misc = 0, wr_trig = 0, ms;
  logic [2:0] wr_data = 0, wr_dir = 0, wr_opt = 0, port_irq;
  logic [7:0] wdata = 0, pa_in, pa_out, pa_oe, pa_pullup, pa_analog;
  logic [7:0] pb_in, pb_out, pb_oe, pb_pullup, second_port_direction;
  logic [7:0] first_port_level_reg, second_port_level_reg;
  logic [4:0] pc_in, pc_out, pc_oe, pc_pullup, pc_analog;
  logic [4:0] third_port_level_reg, third_port_direction;
  logic       timer_pin_drive_select = 0, timer_out = 0, spi_serial_data_out_pin = 0;
  logic       pwm_pin_drive_enable = 0, pwm_out = 0, spi_sck_out = 0;
  logic       serial_clock_source_select = 0;
  logic       timer_in, reload_timer_in, spi_sin, spi_sck_in;
  logic [7:0] dv, ov, xv, oa, ob, po, tr, ib, ea = 0, eb = 0, na = 0, nb = 0;
  logic [4:0] oc, pco, pcp, ic, ec = 0, nc = 0;
  logic [7:0] n;
  int         err_count = 0, cmp_count = 0;
  gpio_port_alt_function_mux uut (.*);
  pin_world #(.W(8)) wa (.clk(clk), .oe(pa_oe), .out(pa_out),
    .pu(pa_pullup), .ext_en(na), .ext_val(ea), .pin(pa_in));
  pin_world #(.W(8)) wb (.clk(clk), .oe(pb_oe), .out(pb_out),
    .pu(pb_pullup), .ext_en(nb), .ext_val(eb), .pin(pb_in));
  pin_world #(.W(`PORT_C_WIDTH)) wc (.clk(clk), .oe(pc_oe), .out(pc_out),
    .pu(pc_pullup), .ext_en(nc), .ext_val(ec), .pin(pc_in));
  always #5 clk = ~clk;
  // ==========================================================================
  // Whole-byte register write: 0 dir, 1 option, 2 data, 3 misc, 4 trigger.
  task automatic put(input int k, input logic [7:0] v);
    @(negedge clk);
    wdata = v;
    {wr_dir, wr_opt, wr_data} = {{3{k == 0}}, {3{k == 1}}, {3{k == 2}}};
    {wr_misc, wr_trig} = {k == 3, k == 4};
    @(negedge clk);
    {wr_dir, wr_opt, wr_data, wr_misc, wr_trig} = 11'h000;
  endtask
  task automatic close_out;
    if (err_count == 0 && cmp_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // ==========================================================================
  initial begin
    void'($urandom(18));
    // A real falling edge puts every register into reset before any clock.
    #1;
    rstn = 0;
    repeat (16) @(negedge clk);
    rstn = 1;
    @(negedge clk);
    `CHK("pullup", 21'h1fffff, {pa_pullup, pb_pullup, pc_pullup})
    `CHK("oe", 21'h0, {pa_oe, pb_oe, pc_oe})
    for (int i = 0; i < 40; i++) begin
      {dv, ov, xv, ea} = $urandom;
      {eb, ec, tr} = 21'($urandom);
      {timer_pin_drive_select, timer_out, pwm_pin_drive_enable, pwm_out,
       serial_clock_source_select, spi_serial_data_out_pin, spi_sck_out, ms} = 8'($urandom);
      ov = ov & (dv | ~xv | 8'h20);
      oa = dv & (ov | ~xv);
      {ob, oc, po} = {oa, oa[4:0], oa & xv};
      ob[7] = oa[7] | pwm_pin_drive_enable;
      oc[1] = oc[1] | timer_pin_drive_select;
      oc[3] = oc[3] | ms;
      oc[4] = oc[4] | (serial_clock_source_select & dv[4] & ov[4]);
      if (pwm_pin_drive_enable) po[7] = pwm_out;
      pco = po[4:0];
      if (timer_pin_drive_select) pco[1] = timer_out;
      if (ms) pco[3] = spi_serial_data_out_pin;
      if (serial_clock_source_select & dv[4] & ov[4]) pco[4] = spi_sck_out;
      {na, nb, nc, pcp} = {~oa, ~ob, ~oc, pco | (~oc & ec)};
      put(0, dv);
      put(1, ov);
      put(2, xv);
      put(3, {7'h00, ms});
      put(4, {2'h0, 1'b1, tr[2], 1'b1, tr[1], 1'b1, tr[0]});
      repeat (6) @(negedge clk);
      `CHK("pa_oe", oa, pa_oe)
      `CHK("pa_out", oa & xv, pa_out & pa_oe)
      `CHK("pa_pullup", ~dv & ~xv, pa_pullup)
      `CHK("pa_analog", ~dv & ov & xv, pa_analog)
      `CHK("level", (dv & xv) | (~dv & ea), first_port_level_reg)
      `CHK("pb_oe", ob, pb_oe)
      `CHK("pb_out", po, pb_out & pb_oe)
      `CHK("pc_oe", oc, pc_oe)
      `CHK("pc_out", pco, pc_out & pc_oe)
      `CHK("reload", po[6] | (~ob[6] & eb[6]), reload_timer_in)
      if (!dv[2]) `CHK("spi_sin", pcp[2], spi_sin)
      if (timer_pin_drive_select) pcp[1] = 1'b0;
      if (timer_pin_drive_select | ~dv[1])
        `CHK("timer_in", pcp[1], timer_in)
      if (!dv[4] & !serial_clock_source_select) begin
        `CHK("sck_in", pcp[4], spi_sck_in)
        `CHK("sck_lvl", pcp[4], third_port_level_reg[4])
      end
      // Overridden lines lose pull-up and interrupt to the peripheral.
      ib = ~dv & ~xv & {~pwm_pin_drive_enable, 7'h7f};
      ic = ~dv[4:0] & ~xv[4:0]
         & {1'b1, ~ms, 1'b1, ~timer_pin_drive_select, 1'b1};
      `CHK("pb_pullup", ib, pb_pullup)
      `CHK("pc_pullup", ic, pc_pullup)
      `CHK("pc_analog", ~dv[4:0] & ov[4:0] & xv[4:0], pc_analog)
      oa = ~dv & ov & ~xv & ~ea;
      `CHK("irq_low", ~tr[0] & |oa, port_irq[0])
      ib = ib & ov & ~eb;
      ic = ic & ov[4:0] & ~ec;
      `CHK("irq_bc", {~tr[2] & |ic, ~tr[1] & |ib}, port_irq[2:1])
    end
    {na, ea} = 16'hffff;
    put(0, 8'h00);
    put(1, 8'hff);
    put(2, 8'h00);
    for (int k = 0; k < 2; k++) begin
      put(4, 8'h3c | 8'(k));
      repeat (6) @(negedge clk);
      ea[0] = k[0];
      n = 8'h00;
      repeat (8) begin
        @(negedge clk);
        n += port_irq[0];
      end
      `CHK("edge_irq", 8'h01, n)
    end
    close_out();
  end
endmodule
